// File: rtl/wrc_pkg.sv
// Constants, types and decode functions for the watchdog and reset control block.
// Assumes a single 125 MHz bus clock and an AXI4-Lite master with 32-bit data.
package wrc_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] WRC_CTRL_OFS = 8'h00;
    localparam logic [7:0] WRC_CAUSE_OFS = 8'h04;
    localparam logic [7:0] WRC_FILT_OFS = 8'h08;
    localparam logic [7:0] WRC_PSTAT_OFS = 8'h0c;

    // ==========================================================
    // Fields and values after reset
    localparam logic [7:0] WRC_CTRL_RST = 8'h53;
    localparam logic [1:0] WRC_FILT_RST = 2'h1;
    localparam logic [4:0] WRC_KEY_A = 5'h15;
    localparam logic [4:0] WRC_KEY_B = 5'h0a;
    localparam int WRC_KEY_LSB = 3;
    localparam int WRC_SOFT_FLAG_BIT = 0;
    localparam int WRC_BROWN_FLAG_BIT = 2;
    localparam int WRC_TIMEOUT_BIT = 0;
    localparam int WRC_PDOWN_BIT = 1;
    localparam logic [1:0] WRC_RESP_OKAY = 2'h0;
    localparam logic [1:0] WRC_RESP_SLVERR = 2'h2;

    // ==========================================================
    // Timing
    localparam int WRC_CLK_PERIOD_NS = 8;
    localparam int WRC_SLOW_OSC_HZ = 32768;
    localparam int WRC_SOFT_DELAY_CYC = 16;
    localparam int WRC_HOLD_CYC = 4;

    typedef enum logic [1:0] {
        WRC_ST_RUN,
        WRC_ST_SOFT_WAIT,
        WRC_ST_HOLD
    } wrc_state_t;

    // Last counter value before overflow, that is 2^n - 1 oscillator periods.
    function automatic logic [17:0] wrc_wdog_max(input logic [2:0] sel);
        case (sel)
            3'h0: wrc_wdog_max = 18'h000ff;
            3'h1: wrc_wdog_max = 18'h003ff;
            3'h2: wrc_wdog_max = 18'h00fff;
            3'h3: wrc_wdog_max = 18'h03fff;
            3'h4: wrc_wdog_max = 18'h07fff;
            3'h5: wrc_wdog_max = 18'h0ffff;
            3'h6: wrc_wdog_max = 18'h1ffff;
            default: wrc_wdog_max = 18'h3ffff;
        endcase
    endfunction

    // Last filter count before a brown-out is accepted.
    function automatic logic [6:0] wrc_filt_max(input logic [1:0] sel);
        case (sel)
            2'h0: wrc_filt_max = 7'h07;
            2'h1: wrc_filt_max = 7'h1f;
            2'h2: wrc_filt_max = 7'h3f;
            default: wrc_filt_max = 7'h7f;
        endcase
    endfunction

endpackage

// File: rtl/wrc_watchdog.sv
// Watchdog timer with key-protected control, brown-out filter and reset cause flags.
// Assumes core instruction strobes on aclk, oscillator and supply detect as raw pins.
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module wrc_watchdog
    import wrc_pkg::*;
#(
    parameter int SOFT_RESET_DELAY_CYC = WRC_SOFT_DELAY_CYC,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read channels
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Core instruction strobes and power mode
    input wire logic clear_watchdog_instruction,
    input wire logic halt_instruction,
    input wire logic sleep_idle,
    // Pins
    input wire logic low_speed_internal_osc,
    input wire logic low_supply_detect,
    // Reset outputs to the core
    output logic core_reset,
    output logic pc_sp_clear
);

    // ==========================================================
    // Pin synchronisers
    logic [2:0] osc_sync;
    logic [2:0] sup_sync;
    logic osc_level;
    logic sup_level;
    wire osc_agree = osc_sync[1] == osc_sync[2];
    wire sup_agree = sup_sync[1] == sup_sync[2];
    wire osc_tick = osc_agree && osc_sync[2] && !osc_level;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_sync <= 3'h0;
            sup_sync <= 3'h0;
            osc_level <= 1'b0;
            sup_level <= 1'b0;
        end else begin
            osc_sync <= {osc_sync[1:0], low_speed_internal_osc};
            sup_sync <= {sup_sync[1:0], low_supply_detect};
            if (osc_agree) osc_level <= osc_sync[2];
            if (sup_agree) sup_level <= sup_sync[2];
        end
    end

    // ==========================================================
    // Registers and state
    logic [7:0] watchdog_control;
    logic [1:0] brownout_filter_width;
    logic soft_reset_cause_flag;
    logic brownout_cause_flag;
    logic timeout_status_flag;
    logic power_down_flag;
    logic [17:0] wcnt;
    logic [6:0] bcnt;
    logic [15:0] dcnt;
    logic [2:0] hcnt;
    wrc_state_t state;
    wrc_state_t next_state;

    wire [4:0] watchdog_key_field = watchdog_control[7:WRC_KEY_LSB];
    wire [2:0] timeout_period_select = watchdog_control[2:0];
    wire key_ok = watchdog_key_field == WRC_KEY_A || watchdog_key_field == WRC_KEY_B;
    wire running = state == WRC_ST_RUN;
    // Greater-or-equal, so a period shortened below the running count still times out on the next oscillator tick.
    wire wdog_ovf = running && key_ok && osc_tick
        && wcnt >= wrc_wdog_max(timeout_period_select);
    wire ovf_full = wdog_ovf && !sleep_idle;
    wire ovf_sleep = wdog_ovf && sleep_idle;
    wire brown_trip = running && sup_level && !sleep_idle && osc_tick
        && bcnt == wrc_filt_max(brownout_filter_width);
    wire soft_done = state == WRC_ST_SOFT_WAIT
        && dcnt == 16'(SOFT_RESET_DELAY_CYC - 1);
    wire hold_done = state == WRC_ST_HOLD && hcnt == 3'(WRC_HOLD_CYC - 1);

    // ==========================================================
    // Reset sequencer
    always_comb begin
        next_state = state;
        case (state)
            WRC_ST_RUN: begin
                if (ovf_full || brown_trip) next_state = WRC_ST_HOLD;
                else if (!key_ok) next_state = WRC_ST_SOFT_WAIT;
            end
            WRC_ST_SOFT_WAIT: begin
                if (soft_done) next_state = WRC_ST_HOLD;
            end
            WRC_ST_HOLD: begin
                if (hold_done) next_state = WRC_ST_RUN;
            end
            default: next_state = WRC_ST_HOLD;
        endcase
    end

    // Power-on starts in the hold state so the core sees the same reset pulse as any other.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= WRC_ST_HOLD;
            core_reset <= 1'b1;
            pc_sp_clear <= 1'b0;
            dcnt <= 16'h0;
            hcnt <= 3'h0;
        end else begin
            state <= next_state;
            core_reset <= next_state == WRC_ST_HOLD;
            pc_sp_clear <= ovf_sleep;
            dcnt <= (state == WRC_ST_SOFT_WAIT) ? dcnt + 16'h1 : 16'h0;
            hcnt <= (state == WRC_ST_HOLD) ? hcnt + 3'h1 : 3'h0;
        end
    end

    // ==========================================================
    // Watchdog and brown-out counters
    wire wdog_clear = clear_watchdog_instruction || halt_instruction || !running
        || !key_ok || wdog_ovf;
    wire filt_clear = !sup_level || sleep_idle || !running || brown_trip;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wcnt <= 18'h0;
            bcnt <= 7'h0;
        end else begin
            if (wdog_clear) wcnt <= 18'h0;
            else if (osc_tick) wcnt <= wcnt + 18'h1;
            if (filt_clear) bcnt <= 7'h0;
            else if (osc_tick) bcnt <= bcnt + 7'h1;
        end
    end

    // ==========================================================
    // AXI4-Lite slave
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    wire aw_take = awvalid && awready;
    wire w_take = wvalid && wready;
    wire do_write = aw_held && w_held && !bvalid;
    wire ar_take = arvalid && arready;
    assign awready = !aw_held;
    assign wready = !w_held;
    assign arready = !rvalid;

    wire wr_ctrl = do_write && w_lane0 && aw_addr[7:0] == WRC_CTRL_OFS;
    wire wr_cause = do_write && w_lane0 && aw_addr[7:0] == WRC_CAUSE_OFS;
    wire wr_filt = do_write && w_lane0 && aw_addr[7:0] == WRC_FILT_OFS;
    wire wr_known = aw_addr[7:0] == WRC_CTRL_OFS || aw_addr[7:0] == WRC_CAUSE_OFS
        || aw_addr[7:0] == WRC_FILT_OFS || aw_addr[7:0] == WRC_PSTAT_OFS;
    wire rd_known = araddr[7:0] == WRC_CTRL_OFS || araddr[7:0] == WRC_CAUSE_OFS
        || araddr[7:0] == WRC_FILT_OFS || araddr[7:0] == WRC_PSTAT_OFS;
    wire [7:0] cause_read = {5'h0, brownout_cause_flag, 1'b0, soft_reset_cause_flag};
    wire [7:0] rd_mux = (araddr[7:0] == WRC_CTRL_OFS) ? watchdog_control
        : (araddr[7:0] == WRC_CAUSE_OFS) ? cause_read
        : (araddr[7:0] == WRC_FILT_OFS) ? {6'h0, brownout_filter_width}
        : (araddr[7:0] == WRC_PSTAT_OFS) ? {6'h0, power_down_flag, timeout_status_flag}
        : 8'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_byte <= 8'h0;
            w_lane0 <= 1'b0;
            bvalid <= 1'b0;
            bresp <= WRC_RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= WRC_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_byte <= wdata[7:0];
                w_lane0 <= wstrb[0];
            end else if (do_write) begin
                w_held <= 1'b0;
            end
            if (do_write) begin
                bvalid <= 1'b1;
                bresp <= wr_known ? WRC_RESP_OKAY : WRC_RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
            if (ar_take) begin
                rvalid <= 1'b1;
                rdata <= {24'h0, rd_mux};
                rresp <= rd_known ? WRC_RESP_OKAY : WRC_RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Control registers and flags
    // A full reset reloads control and filter select but never the cause flags, so software
    // can still tell after the restart why it happened. Flag sets win over software clears.
    wire full_reinit = state == WRC_ST_HOLD;
    wire soft_set = soft_done;
    wire brown_set = brown_trip;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            watchdog_control <= WRC_CTRL_RST;
            brownout_filter_width <= WRC_FILT_RST;
            soft_reset_cause_flag <= 1'b0;
            brownout_cause_flag <= 1'b0;
            timeout_status_flag <= 1'b0;
            power_down_flag <= 1'b0;
        end else begin
            if (full_reinit) begin
                watchdog_control <= WRC_CTRL_RST;
                brownout_filter_width <= WRC_FILT_RST;
            end else begin
                if (wr_ctrl) watchdog_control <= w_byte;
                if (wr_filt) brownout_filter_width <= w_byte[1:0];
            end
            if (soft_set) soft_reset_cause_flag <= 1'b1;
            else if (wr_cause) soft_reset_cause_flag <= w_byte[WRC_SOFT_FLAG_BIT];
            if (brown_set) brownout_cause_flag <= 1'b1;
            else if (wr_cause) brownout_cause_flag <= w_byte[WRC_BROWN_FLAG_BIT];
            // A brown-out leaves both status flags untouched.
            if (wdog_ovf) timeout_status_flag <= 1'b1;
            else if (halt_instruction || clear_watchdog_instruction) timeout_status_flag <= 1'b0;
            if (halt_instruction) power_down_flag <= 1'b1;
            else if (clear_watchdog_instruction) power_down_flag <= 1'b0;
        end
    end

    // ==========================================================
    // Assertions
    default clocking wrc_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    key_reset_a: assert property (
        running && !key_ok && !ovf_full && !brown_trip |=> state == WRC_ST_SOFT_WAIT)
        else $error("bad key did not start soft reset");
    soft_delay_a: assert property (
        soft_done |=> core_reset && soft_reset_cause_flag)
        else $error("soft reset did not follow its delay");
    por_value_a: assert property (
        $fell(core_reset) |-> watchdog_control == WRC_CTRL_RST
        && brownout_filter_width == WRC_FILT_RST)
        else $error("control not at reset value");
    period_bound_a: assert property (
        running && osc_tick |=> wcnt <= wrc_wdog_max($past(timeout_period_select)))
        else $error("watchdog count passed its period");
    counter_clear_a: assert property (
        clear_watchdog_instruction || halt_instruction |=> wcnt == 18'h0)
        else $error("watchdog counter not cleared");
    full_timeout_a: assert property (
        ovf_full |=> core_reset && timeout_status_flag ##1 core_reset)
        else $error("run mode overflow did not reset");
    sleep_timeout_a: assert property (
        ovf_sleep |=> pc_sp_clear && timeout_status_flag && !core_reset)
        else $error("sleep overflow wrong reset");
    brown_reset_a: assert property (
        brown_trip |=> core_reset && brownout_cause_flag && $stable(timeout_status_flag))
        else $error("brown-out reset wrong");
    sleep_filter_a: assert property (
        sleep_idle |=> bcnt == 7'h0)
        else $error("brown-out filter ran in sleep");
    reserved_zero_a: assert property (
        $rose(rvalid) |-> rdata[31:8] == 24'h0
        && ($past(araddr[7:0]) != WRC_CAUSE_OFS || (rdata[7:3] == 5'h0 && rdata[1] == 1'b0))
        && ($past(araddr[7:0]) != WRC_FILT_OFS || rdata[7:2] == 6'h0))
        else $error("reserved bits read nonzero");

endmodule

// File: verification/watchdog_and_reset_control_bench.sv
// Self-checking bench for the watchdog and reset control block.
// Assumes the block answers on AXI4-Lite and counts ticks of a free-running oscillator pin.
`timescale 1ns/10ps
module watchdog_and_reset_control_bench;
    import wrc_pkg::*;
    // ==========================================================
    // Signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, core_reset, pc_sp_clear;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic clr_wd = 1'b0, halt = 1'b0, sleep_idle = 1'b0, osc = 1'b0, low_supply = 1'b0;
    logic [2:0] osc_div = 3'h0;
    logic [31:0] rdq[$], rrq[$], bq[$];
    logic [31:0] d;
    logic hit;
    int failures = 0, n_tests = 0, cyc = 0, seed = 32'h2a15;

    always #4 aclk = ~aclk;

    // The oscillator pin runs free, one tick every eight bus cycles.
    always @(posedge aclk) begin
        osc_div <= osc_div + 3'h1;
        osc <= osc_div[2];
    end

    wrc_watchdog #(.SOFT_RESET_DELAY_CYC(4), .ADDR_W(8)) u_wrc_watchdog (
        .aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .clear_watchdog_instruction(clr_wd), .halt_instruction(halt), .sleep_idle(sleep_idle),
        .low_speed_internal_osc(osc), .low_supply_detect(low_supply),
        .core_reset(core_reset), .pc_sp_clear(pc_sp_clear)
    );

    // ==========================================================
    // Checking and closing
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            report_and_stop();
        end
    end

    // Responses are matched against the oldest expectation noted by the driver.
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready) begin
            check(rdata, rdq.pop_front());
            check({30'h0, rresp}, rrq.pop_front());
        end
        if (bvalid === 1'b1 && bready) begin
            check({30'h0, bresp}, bq.pop_front());
        end
    end

    // ==========================================================
    // Drivers
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] r = WRC_RESP_OKAY);
        @(posedge aclk);
        bq.push_back(32'(r));
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
        @(posedge aclk);
        rdq.push_back(v);
        rrq.push_back(32'(r));
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask

    task automatic pulse(input bit use_halt);
        @(posedge aclk);
        if (use_halt) halt <= 1'b1;
        else clr_wd <= 1'b1;
        @(posedge aclk);
        halt <= 1'b0;
        clr_wd <= 1'b0;
    endtask

    // Kind 0 waits for core_reset high, 1 for pc_sp_clear high, 2 for core_reset low.
    task automatic wait_for(input int kind, input int n);
        hit = 1'b0;
        for (int i = 0; i < n && !hit; i++) begin
            @(posedge aclk);
            hit = (kind == 0) ? (core_reset === 1'b1) :
                  (kind == 1) ? (pc_sp_clear === 1'b1) : (core_reset === 1'b0);
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        wait_for(2, 20);
        check(hit, 1'b1);
        rd(WRC_CTRL_OFS, 32'h53, WRC_RESP_OKAY);
        rd(WRC_FILT_OFS, 32'h01, WRC_RESP_OKAY);
        rd(WRC_CAUSE_OFS, 32'h0, WRC_RESP_OKAY);
        rd(WRC_PSTAT_OFS, 32'h0, WRC_RESP_OKAY);
        rd(8'h10, 32'h0, WRC_RESP_SLVERR);
        wr(8'h10, 32'hff, WRC_RESP_SLVERR);
        wr(WRC_PSTAT_OFS, 32'hff);
        rd(WRC_PSTAT_OFS, 32'h0, WRC_RESP_OKAY);
        d = $random(seed);
        wr(WRC_FILT_OFS, d);
        rd(WRC_FILT_OFS, d & 32'h3, WRC_RESP_OKAY);
        wr(WRC_CAUSE_OFS, 32'hff);
        rd(WRC_CAUSE_OFS, 32'h05, WRC_RESP_OKAY);
        wr(WRC_CAUSE_OFS, 32'h0);
        // Period codes 0 and 1: no overflow one tick early, reset soon after the last tick.
        for (int k = 0; k < 2; k++) begin
            wr(WRC_CTRL_OFS, {24'h0, k[0] ? WRC_KEY_A : WRC_KEY_B, k[0] ? 3'h1 : 3'h0});
            pulse(1'b0);
            repeat (((1 << (8 + 2 * k)) - 1) * 8 - 4) @(posedge aclk);
            check(core_reset, 1'b0);
            wait_for(0, 40);
            check(hit, 1'b1);
            wait_for(2, 20);
            rd(WRC_PSTAT_OFS, 32'h1, WRC_RESP_OKAY);
            rd(WRC_CTRL_OFS, 32'h53, WRC_RESP_OKAY);
        end
        // Regular clears keep the shortest period from expiring.
        wr(WRC_CTRL_OFS, {24'h0, WRC_KEY_B, 3'h0});
        for (int i = 0; i < 4; i++) begin
            repeat (1500) @(posedge aclk);
            pulse(i[0]);
            check(core_reset, 1'b0);
        end
        rd(WRC_PSTAT_OFS, 32'h2, WRC_RESP_OKAY);
        pulse(1'b0);
        rd(WRC_PSTAT_OFS, 32'h0, WRC_RESP_OKAY);
        // Overflow while asleep only clears PC and SP; brown-out is off meanwhile.
        wr(WRC_FILT_OFS, 32'h0);
        sleep_idle <= 1'b1;
        pulse(1'b0);
        wait_for(1, 2300);
        check(hit, 1'b1);
        wr(WRC_CTRL_OFS, {24'h0, WRC_KEY_A, 3'h7});
        low_supply <= 1'b1;
        repeat (200) @(posedge aclk);
        check(core_reset, 1'b0);
        low_supply <= 1'b0;
        repeat (40) @(posedge aclk);
        sleep_idle <= 1'b0;
        rd(WRC_PSTAT_OFS, 32'h1, WRC_RESP_OKAY);
        // A short dip is filtered out, a long one resets.
        low_supply <= 1'b1;
        repeat (32) @(posedge aclk);
        low_supply <= 1'b0;
        repeat (60) @(posedge aclk);
        check(core_reset, 1'b0);
        low_supply <= 1'b1;
        wait_for(0, 120);
        check(hit, 1'b1);
        low_supply <= 1'b0;
        wait_for(2, 20);
        rd(WRC_CAUSE_OFS, 32'h04, WRC_RESP_OKAY);
        rd(WRC_PSTAT_OFS, 32'h1, WRC_RESP_OKAY);
        rd(WRC_FILT_OFS, 32'h01, WRC_RESP_OKAY);
        // A bad key resets after the fixed delay and marks the soft-reset cause.
        wr(WRC_CTRL_OFS, 32'h0);
        check(core_reset, 1'b0);
        wait_for(0, 20);
        check(hit, 1'b1);
        wait_for(2, 20);
        rd(WRC_CAUSE_OFS, 32'h05, WRC_RESP_OKAY);
        rd(WRC_CTRL_OFS, 32'h53, WRC_RESP_OKAY);
        wr(WRC_CAUSE_OFS, 32'h0);
        rd(WRC_CAUSE_OFS, 32'h0, WRC_RESP_OKAY);
        repeat (4) @(posedge aclk);
        report_and_stop();
    end
endmodule
